// [design/decoder_pkg.sv]
// constants shared by the jump and flag decoder
package decoder_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_INSTR  = 8'h00;
    localparam logic [7:0] OFS_FLAGS  = 8'h04;
    localparam logic [7:0] OFS_ACC    = 8'h08;
    localparam logic [7:0] OFS_EXTRA  = 8'h0C;
    localparam logic [7:0] OFS_RESULT = 8'h10;
    // flag_register bit positions
    localparam int FLG_C = 0;
    localparam int FLG_V = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_N = 3;
    localparam int FLG_I = 4;
    localparam int FLG_H = 5;
    localparam int FLG_F = 6;
    // result register field positions
    localparam int RES_BYTES = 8;
    localparam int RES_TAKEN = 12;
    localparam int RES_LONG  = 13;
    localparam int RES_BAD   = 14;
    localparam int RES_DONE  = 15;
    localparam int RES_BUSY  = 16;
    // reset values
    localparam logic [7:0]  FLAGS_RST = 8'h50;
    localparam logic [15:0] ACC_RST   = 16'h0000;
    localparam logic [23:0] INSTR_RST = 24'h000012;
    // prefixes and opcodes
    localparam logic [7:0] PFX_PAGE2  = 8'h10;
    localparam logic [7:0] PFX_PAGE3  = 8'h11;
    localparam logic [7:0] OP_NOP     = 8'h12;
    localparam logic [7:0] OP_LJUMP   = 8'h16;
    localparam logic [7:0] OP_LCALL   = 8'h17;
    localparam logic [7:0] OP_WIDEN   = 8'h1D;
    localparam logic [7:0] OP_SWAP    = 8'h1E;
    localparam logic [7:0] OP_COPY    = 8'h1F;
    localparam logic [7:0] OP_PRODUCT = 8'h3D;
    localparam logic [7:0] OP_TRAP    = 8'h3F;
    localparam logic [7:0] OP_SHR_A   = 8'h47;
    localparam logic [7:0] OP_SHL_A   = 8'h48;
    localparam logic [7:0] OP_SUB_IMM = 8'h80;
    localparam logic [7:0] OP_CMP_IMM = 8'h81;
    localparam logic [7:0] OP_SBC_IMM = 8'h82;
    localparam logic [7:0] OP_ADC_IMM = 8'h89;
    localparam logic [7:0] OP_ADD_IMM = 8'h8B;
    localparam logic [7:0] OP_CALL    = 8'h8D;
    localparam logic [3:0] GRP_JUMP   = 4'h2;
    localparam logic [3:0] GRP_STACK  = 4'h3;
    // cycle counts
    localparam logic [5:0] CYC_SHORT  = 6'h03;
    localparam logic [5:0] CYC_LNOT   = 6'h05;
    localparam logic [5:0] CYC_LTAKEN = 6'h06;
    localparam logic [5:0] CYC_LJUMP  = 6'h05;
    localparam logic [5:0] CYC_CALL   = 6'h07;
    localparam logic [5:0] CYC_LCALL  = 6'h09;
    localparam logic [5:0] CYC_STACK  = 6'h05;
    localparam logic [5:0] CYC_COPY   = 6'h06;
    localparam logic [5:0] CYC_SWAP   = 6'h08;
    localparam logic [5:0] CYC_TRAP1  = 6'h13;
    localparam logic [5:0] CYC_TRAP23 = 6'h14;
    localparam logic [5:0] CYC_PROD   = 6'h0B;
    localparam logic [5:0] CYC_TWO    = 6'h02;
    localparam logic [5:0] CYC_IDX4   = 6'h04;
    localparam logic [5:0] CYC_IDX5   = 6'h05;
    localparam logic [5:0] CYC_IDX6   = 6'h06;
    localparam logic [5:0] CYC_IDX7   = 6'h07;
    // byte lengths
    localparam logic [3:0] LEN_ONE    = 4'h1;
    localparam logic [3:0] LEN_TWO    = 4'h2;
    localparam logic [3:0] LEN_THREE  = 4'h3;
    localparam logic [3:0] LEN_FOUR   = 4'h4;
endpackage : decoder_pkg

// [design/branch_and_flag_decoder.sv]
// jump and flag decoder with its apb register file
`timescale 1ns/10ps

module branch_and_flag_decoder
    import decoder_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // decode completion
    output logic             decode_done
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic branch_holds(input logic [3:0] c, input logic [7:0] f);
        logic r;
        case (c)
            4'h0: r = 1'b1;
            4'h1: r = 1'b0;
            4'h2: r = ~f[FLG_C] & ~f[FLG_Z];
            4'h3: r = f[FLG_C] | f[FLG_Z];
            4'h4: r = ~f[FLG_C];
            4'h5: r = f[FLG_C];
            4'h6: r = ~f[FLG_Z];
            4'h7: r = f[FLG_Z];
            4'h8: r = ~f[FLG_V];
            4'h9: r = f[FLG_V];
            4'hA: r = ~f[FLG_N];
            4'hB: r = f[FLG_N];
            4'hC: r = f[FLG_N] == f[FLG_V];
            4'hD: r = f[FLG_N] != f[FLG_V];
            4'hE: r = ~f[FLG_Z] & (f[FLG_N] == f[FLG_V]);
            default: r = f[FLG_Z] | (f[FLG_N] != f[FLG_V]);
        endcase
        return r;
    endfunction : branch_holds

    // word registers take two bytes per list bit, byte registers one
    function automatic logic [5:0] stack_bytes(input logic [7:0] p);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 8; i++)
            n = n + ((i > 3) ? {4'h0, p[i], 1'b0} : {5'h00, p[i]});
        return n;
    endfunction : stack_bytes

    function automatic logic reg_code_ok(input logic [3:0] r);
        return r[3] ? (r <= 4'hB) : (r <= 4'h5);
    endfunction : reg_code_ok

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        for (int i = 0; i < 4; i++)
            r[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        return r;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////
    // state

    logic [23:0] instr_ff;
    logic [7:0]  flags_ff;
    logic [15:0] acc_ff;
    logic [5:0]  xcyc_ff;
    logic [3:0]  xlen_ff;
    logic [5:0]  cycles_ff;
    logic [3:0]  bytes_ff;
    logic        taken_ff;
    logic        long_ff;
    logic        bad_ff;
    logic        start_ff;
    logic        done_ff;
    logic [31:0] prdata_ff;
    logic        slverr_ff;

    logic        setup;
    logic        wr;
    logic [31:0] wword;
    logic        has_pre;
    logic [7:0]  op;
    logic [7:0]  post;
    logic [7:0]  ra;
    logic [7:0]  rb;
    logic        hold;
    logic        cin;
    logic [8:0]  sum;
    logic [4:0]  low;
    logic [15:0] prod;
    logic [5:0]  idx_base;
    logic [5:0]  nxt_cycles;
    logic [3:0]  nxt_bytes;
    logic        nxt_taken;
    logic        nxt_long;
    logic        nxt_bad;
    logic [7:0]  nxt_flags;
    logic [15:0] nxt_acc;
    logic [31:0] flag_word;
    logic [31:0] acc_word;

    ////////////////////////////////////////////////////////////////////
    // apb slave: zero wait states, read data captured in the setup cycle

    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite;
    assign pready  = psel & penable;
    assign prdata  = prdata_ff;
    assign pslverr = slverr_ff & psel & penable;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            prdata_ff <= 32'h00000000;
            slverr_ff <= 1'b0;
        end
        else if (setup)
        begin
            slverr_ff <= 1'b0;
            case (paddr)
                OFS_INSTR:  prdata_ff <= {8'h00, instr_ff};
                OFS_FLAGS:  prdata_ff <= {24'h000000, flags_ff};
                OFS_ACC:    prdata_ff <= {16'h0000, acc_ff};
                OFS_EXTRA:  prdata_ff <= {20'h00000, xlen_ff, 2'b00, xcyc_ff};
                OFS_RESULT: prdata_ff <= {15'h0000, start_ff, done_ff, bad_ff, long_ff,
                                          taken_ff, bytes_ff, 2'b00, cycles_ff};
                default:
                begin
                    prdata_ff <= 32'h00000000;
                    slverr_ff <= 1'b1;
                end
            endcase
        end
    end

    // a write to the instruction register launches one decode
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            instr_ff <= INSTR_RST;
            start_ff <= 1'b0;
        end
        else
        begin
            start_ff <= wr && (paddr == OFS_INSTR);
            if (wr && (paddr == OFS_INSTR))
                instr_ff <= wword[23:0];
        end
    end

    assign wword = merge(32'h00000000 | {8'h00, instr_ff}, pwdata, pstrb);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            xcyc_ff <= 6'h00;
            xlen_ff <= 4'h0;
        end
        else if (wr && (paddr == OFS_EXTRA))
        begin
            xcyc_ff <= pwdata[5:0];
            xlen_ff <= pwdata[11:8];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decode

    always_comb
    begin
        has_pre = (instr_ff[7:0] == PFX_PAGE2) || (instr_ff[7:0] == PFX_PAGE3);
        op      = has_pre ? instr_ff[15:8] : instr_ff[7:0];
        post    = has_pre ? instr_ff[23:16] : instr_ff[15:8];
        ra      = acc_ff[15:8];
        rb      = acc_ff[7:0];
        cin     = flags_ff[FLG_C] & (op == OP_ADC_IMM || op == OP_SBC_IMM);
        hold    = branch_holds(op[3:0], flags_ff);
        low     = {1'b0, ra[3:0]} + {1'b0, post[3:0]} + {4'h0, cin};
        sum     = {1'b0, ra} + {1'b0, post} + {8'h00, cin};
        // only the 80..82 forms subtract; 89 and 8B add
        if (op[7:4] == 4'h8 && !op[3])
            sum = {1'b0, ra} - {1'b0, post} - {8'h00, cin};
        prod    = {8'h00, ra} * {8'h00, rb};
        case (op[3:0])
            4'h3, 4'hC: idx_base = CYC_IDX6;
            4'hD:       idx_base = CYC_IDX7;
            4'hE, 4'hF: idx_base = CYC_IDX5;
            default:    idx_base = CYC_IDX4;
        endcase
        nxt_cycles = CYC_TWO;
        nxt_bytes  = LEN_ONE;
        nxt_taken  = 1'b0;
        nxt_long   = 1'b0;
        nxt_bad    = 1'b0;
        nxt_flags  = flags_ff;
        nxt_acc    = acc_ff;
        if (has_pre)
        begin
            if (instr_ff[7:0] == PFX_PAGE2 && op[7:4] == GRP_JUMP)
            begin
                nxt_long   = 1'b1;
                nxt_bytes  = LEN_FOUR;
                nxt_taken  = hold;
                nxt_cycles = hold ? CYC_LTAKEN : CYC_LNOT;
            end
            else if (op == OP_TRAP)
            begin
                nxt_cycles = CYC_TRAP23;
                nxt_bytes  = LEN_TWO;
            end
            else
                nxt_bad = 1'b1;
        end
        else if (op[7:4] == GRP_JUMP)
        begin
            nxt_cycles = CYC_SHORT;
            nxt_bytes  = LEN_TWO;
            nxt_taken  = hold;
        end
        else if (op[7:4] == 4'h6 || op[7:4] == 4'hA || op[7:4] == 4'hE)
        begin
            nxt_cycles = op[7:4] == 4'h6 ? CYC_IDX6 + xcyc_ff : idx_base + xcyc_ff;
            nxt_bytes  = LEN_TWO + xlen_ff;
        end
        else
        begin
            case (op)
                OP_LJUMP, OP_LCALL:
                begin
                    nxt_long   = 1'b1;
                    nxt_taken  = 1'b1;
                    nxt_bytes  = LEN_THREE;
                    nxt_cycles = op == OP_LJUMP ? CYC_LJUMP : CYC_LCALL;
                end
                OP_CALL:
                begin
                    nxt_taken  = 1'b1;
                    nxt_bytes  = LEN_TWO;
                    nxt_cycles = CYC_CALL;
                end
                OP_WIDEN:
                begin
                    nxt_acc[15:8]    = {8{rb[7]}};
                    nxt_flags[FLG_N] = rb[7];
                    nxt_flags[FLG_Z] = rb == 8'h00;
                end
                OP_PRODUCT:
                begin
                    nxt_cycles       = CYC_PROD;
                    nxt_acc          = prod;
                    nxt_flags[FLG_Z] = prod == 16'h0000;
                    nxt_flags[FLG_C] = prod[7];
                end
                OP_SWAP, OP_COPY:
                begin
                    nxt_bytes  = LEN_TWO;
                    nxt_cycles = op == OP_SWAP ? CYC_SWAP : CYC_COPY;
                    nxt_bad    = !(reg_code_ok(post[7:4]) && reg_code_ok(post[3:0])
                                   && post[7] == post[3]);
                end
                8'h34, 8'h35, 8'h36, 8'h37:
                begin
                    nxt_bytes  = LEN_TWO;
                    nxt_cycles = CYC_STACK + stack_bytes(post);
                end
                OP_TRAP:
                begin
                    nxt_cycles       = CYC_TRAP1;
                    nxt_flags[FLG_I] = 1'b1;
                    nxt_flags[FLG_F] = 1'b1;
                end
                OP_NOP: ;
                OP_ADD_IMM, OP_ADC_IMM, OP_SUB_IMM, OP_CMP_IMM, OP_SBC_IMM:
                begin
                    nxt_bytes        = LEN_TWO;
                    nxt_flags[FLG_N] = sum[7];
                    nxt_flags[FLG_Z] = sum[7:0] == 8'h00;
                    nxt_flags[FLG_C] = sum[8];
                    // subtract forms leave half-carry free; zero is written
                    nxt_flags[FLG_H] = op[3] ? low[4] : 1'b0;
                    nxt_flags[FLG_V] = op[3] ? (ra[7] == post[7]) && (sum[7] != ra[7])
                                             : (ra[7] != post[7]) && (sum[7] != ra[7]);
                    if (op != OP_CMP_IMM)
                        nxt_acc[15:8] = sum[7:0];
                end
                OP_SHL_A, OP_SHR_A:
                begin
                    nxt_acc[15:8]    = op[3] ? {ra[6:0], 1'b0} : {ra[7], ra[7:1]};
                    nxt_flags[FLG_C] = op[3] ? ra[7] : ra[0];
                    nxt_flags[FLG_N] = nxt_acc[15];
                    nxt_flags[FLG_Z] = nxt_acc[15:8] == 8'h00;
                    nxt_flags[FLG_H] = 1'b0;
                    if (op[3])
                        nxt_flags[FLG_V] = ra[7] ^ ra[6];
                end
                default: nxt_bad = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // results and architectural state

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cycles_ff <= 6'h00;
            bytes_ff  <= 4'h0;
            taken_ff  <= 1'b0;
            long_ff   <= 1'b0;
            bad_ff    <= 1'b0;
            done_ff   <= 1'b0;
        end
        else
        begin
            done_ff <= start_ff;
            if (start_ff)
            begin
                cycles_ff <= nxt_cycles;
                bytes_ff  <= nxt_bytes;
                taken_ff  <= nxt_taken;
                long_ff   <= nxt_long;
                bad_ff    <= nxt_bad;
            end
        end
    end

    assign decode_done = done_ff;

    assign flag_word = merge({24'h000000, flags_ff}, pwdata, pstrb) & 32'h0000007F;
    assign acc_word  = merge({16'h0000, acc_ff}, pwdata, pstrb);

    // a decode never meets a software write: apb needs a setup cycle first
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            flags_ff <= FLAGS_RST;
            acc_ff   <= ACC_RST;
        end
        else if (start_ff)
        begin
            flags_ff <= nxt_flags;
            acc_ff   <= nxt_acc;
        end
        else if (wr && paddr == OFS_FLAGS)
            flags_ff <= flag_word[7:0];
        else if (wr && paddr == OFS_ACC)
            acc_ff <= acc_word[15:0];
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    chk_short_jump_len: assert property (
        done_ff && instr_ff[7:4] == GRP_JUMP |-> cycles_ff == 6'h03 && bytes_ff == 4'h2)
        else $error("short jump count wrong");

    chk_long_cond_len: assert property (
        done_ff && instr_ff[7:0] == 8'h10 && instr_ff[15:12] == 4'h2
        |-> long_ff && bytes_ff == 4'h4 && cycles_ff == (taken_ff ? 6'h06 : 6'h05))
        else $error("long jump count wrong");

    chk_never_taken: assert property (
        done_ff && (instr_ff[7:0] == 8'h21 || instr_ff[15:0] == 16'h2110)
        |-> !taken_ff && cycles_ff == (long_ff ? 6'h05 : 6'h03))
        else $error("never-taken jump misdecoded");

    chk_stack_cycles: assert property (
        done_ff && instr_ff[7:2] == 6'h0D
        |-> cycles_ff == 6'h05 + stack_bytes(instr_ff[15:8]))
        else $error("stack cycle count wrong");

    chk_trap_masks: assert property (
        start_ff && instr_ff[15:0] == 16'h3F11
        |=> flags_ff[FLG_I] == $past(flags_ff[FLG_I])
            && flags_ff[FLG_F] == $past(flags_ff[FLG_F]) && cycles_ff == 6'h14)
        else $error("prefixed trap touched masks");

    chk_trap_one: assert property (
        start_ff && instr_ff[7:0] == 8'h3F |=> flags_ff[FLG_I] && flags_ff[FLG_F])
        else $error("trap one left masks clear");

    chk_product_flags: assert property (
        start_ff && instr_ff[7:0] == 8'h3D
        |=> acc_ff == $past(acc_ff[15:8]) * $past(acc_ff[7:0])
            && flags_ff[FLG_C] == acc_ff[7] && cycles_ff == 6'h0B)
        else $error("product result wrong");

    chk_half_carry: assert property (
        start_ff && instr_ff[7:0] == 8'h8B
        |=> flags_ff[FLG_H] == ((5'($past(acc_ff[11:8])) + 5'($past(instr_ff[11:8]))) > 5'h0F))
        else $error("half-carry wrong");

    chk_equal_test: assert property (
        start_ff && instr_ff[7:0] == 8'h27 |=> taken_ff == $past(flags_ff[FLG_Z]))
        else $error("equal jump test wrong");

    chk_signed_less: assert property (
        start_ff && instr_ff[7:0] == 8'h2D
        |=> taken_ff == ($past(flags_ff[FLG_N]) ^ $past(flags_ff[FLG_V])))
        else $error("signed less test wrong");

    chk_sign_widen: assert property (
        start_ff && instr_ff[7:0] == 8'h1D
        |=> acc_ff[15:8] == {8{acc_ff[7]}} && flags_ff[FLG_N] == acc_ff[7])
        else $error("sign widen wrong");

    cov_long_taken: cover property (done_ff && long_ff && taken_ff && bytes_ff == 4'h4);
    cov_stack: cover property (done_ff && instr_ff[7:4] == GRP_STACK && cycles_ff > 6'h08);
    cov_bad_pair: cover property (done_ff && instr_ff[7:0] == 8'h1F && bad_ff);

endmodule : branch_and_flag_decoder

// [verif/prog_mem.sv]
// program memory model: instruction words handed to the decoder
`timescale 1ns/10ps
module prog_mem
(
    // word select
    input  wire logic [4:0]  idx,
    // instruction bytes, first byte in the low lane
    output logic      [23:0] word
);
    localparam int N = 26;
    localparam logic [23:0] ROM [N] = '{
        24'h000024, 24'h000024, 24'h000027, 24'h000026,
        24'h00002D, 24'h00002C, 24'h00002B, 24'h00002A,
        24'h002410, 24'h002410, 24'h002110, 24'h000021,
        24'h000020, 24'h000016, 24'h00008D, 24'h000017,
        24'h00891E, 24'h00011F, 24'h00081F, 24'h00FF34,
        24'h0004AD, 24'h000001, 24'h00003F, 24'h003F10,
        24'h003F11, 24'h00002D
    };
    // past the program a changing pattern, so a stale word never passes
    always_comb word = (idx < 5'(N)) ? ROM[idx] : {3{idx, 3'h5}};
endmodule : prog_mem

// [verif/branch_and_flag_decoder_tb.sv]
// self-checking bench for the jump and flag decoder
`timescale 1ns/10ps
module branch_and_flag_decoder_tb;
    import decoder_pkg::*;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, decode_done, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [4:0]  idx;
    logic [23:0] word;
    int          n_errors, cmp_count;
    // flags in, flags out, cycles, bytes, taken (2 = any), illegal
    logic [35:0] rows [26] = '{
        36'h0000_03_2_1_0, 36'h0101_03_2_0_0, 36'h0404_03_2_1_0, 36'h0404_03_2_0_0,
        36'h0808_03_2_1_0, 36'h0808_03_2_0_0, 36'h0808_03_2_1_0, 36'h0808_03_2_0_0,
        36'h0000_06_4_1_0, 36'h0101_05_4_0_0, 36'h0000_05_4_0_0, 36'h0000_03_2_0_0,
        36'h0000_03_2_1_0, 36'h0000_05_3_1_0, 36'h0000_07_2_2_0, 36'h0000_09_3_2_0,
        36'h0000_08_2_2_0, 36'h0000_06_2_2_0, 36'h0000_06_2_2_1, 36'h0000_11_2_2_0,
        36'h0000_09_3_2_0, 36'h0000_02_1_2_1, 36'h0050_13_1_2_0, 36'h0000_14_2_2_0,
        36'h0000_14_2_2_0, 36'h0A0A_03_2_0_0
    };
    branch_and_flag_decoder uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .decode_done(decode_done));
    prog_mem pm (.idx(idx), .word(word));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle limit here: only the watchdog ends a stuck transfer
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask : rdchk
    task automatic run(input logic [15:0] acc, input logic [7:0] fl, input logic [23:0] ins);
        int k;
        apb(1'b1, OFS_ACC, {16'h0000, acc});
        apb(1'b1, OFS_FLAGS, {24'h00_0000, fl});
        apb(1'b1, OFS_INSTR, {8'h00, ins});
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (decode_done !== 1'b1 && k < 10);
        chk("decode_done", 32'h0000_0001, {31'h0, decode_done});
    endtask : run
    task automatic finish_test;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test;
    end
    initial
    begin
        logic [35:0] r;
        logic [31:0] m;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        idx = 5'h00;
        n_errors = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rdchk("instr_rst", OFS_INSTR, {8'h00, INSTR_RST});
        rdchk("flags_rst", OFS_FLAGS, {24'h00_0000, FLAGS_RST});
        apb(1'b1, OFS_EXTRA, 32'h0000_0102);
        for (int i = 0; i < 26; i++)
        begin
            r = rows[i];
            idx <= 5'(i);
            @(posedge clk);
            run(16'h0000, r[35:28], word);
            m = (r[5]) ? 32'h0000_4F3F : 32'h0000_5F3F;
            apb(1'b0, OFS_RESULT, 32'h0000_0000);
            chk("result", {17'h0, r[0], 1'b0, r[4], r[11:8], 2'h0, r[17:12]}, rd & m);
            rdchk("flags", OFS_FLAGS, {24'h00_0000, r[27:20]});
            $display("row %0d done", i);
        end
        // accumulator cases: A in the upper byte, B in the lower
        run(16'h0C0D, 8'h00, {16'h0000, OP_PRODUCT});
        rdchk("prod_acc", OFS_ACC, 32'h0000_009C);
        rdchk("prod_flags", OFS_FLAGS, 32'h0000_0001);
        run(16'h0080, 8'h00, {16'h0000, OP_WIDEN});
        rdchk("widen_acc", OFS_ACC, 32'h0000_FF80);
        rdchk("widen_flags", OFS_FLAGS, 32'h0000_0008);
        run(16'h0F00, 8'h00, 24'h00_018B);
        rdchk("add_acc", OFS_ACC, 32'h0000_1000);
        rdchk("add_flags", OFS_FLAGS, 32'h0000_0020);
        run(16'h1000, 8'h20, 24'h00_0180);
        rdchk("sub_acc", OFS_ACC, 32'h0000_0F00);
        rdchk("sub_flags", OFS_FLAGS, 32'h0000_0000);
        $display("accumulator tests done");
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped_err", 32'h0000_0001, {31'h0, err});
        chk("unmapped_data", 32'h0000_0000, rd);
        $display("unmapped test done");
        // second reset in mid-run: state written above must return to reset values
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rdchk("flags_rerst", OFS_FLAGS, {24'h00_0000, FLAGS_RST});
        rdchk("acc_rerst", OFS_ACC, {16'h0000, ACC_RST});
        rdchk("result_rerst", OFS_RESULT, 32'h0000_0000);
        $display("reset test done");
        finish_test;
    end
endmodule : branch_and_flag_decoder_tb
